// ===== rtl/fmc_consts.svh
// named constants for the multiply-add and coprocessor move block
// assumes 32-bit instruction words and a byte-addressed bus
`ifndef FMC_CONSTS_SVH
`define FMC_CONSTS_SVH

// instruction fields
`define FMC_OPC 31:26
`define FMC_SUB 25:21
`define FMC_RT 20:16
`define FMC_RD 15:11
`define FMC_FD 10:6
`define FMC_F3 5:3
`define FMC_FMT 2:0
`define FMC_FN 5:0
`define FMC_SEL 2:0
`define FMC_IMPL 15:0
`define FMC_Z_UMAC 15:6
`define FMC_Z_SYS 10:3
`define FMC_Z_FPC 10:0

// encodings
`define FMC_OP_FPX 6'h13
`define FMC_OP_SP2 6'h1c
`define FMC_OP_SYS 6'h10
`define FMC_OP_FPC 6'h11
`define FMC_OP_CP2 6'h12
`define FMC_SUB_MF 5'h00
`define FMC_SUB_MFH 5'h03
`define FMC_F3_MADD 3'h4
`define FMC_FN_UMAC 6'h01
`define FMC_FMT_S 3'h0
`define FMC_FMT_D 3'h1
`define FMC_FMT_PS 3'h6
`define FMC_HI 63:32
`define FMC_LO 31:0

// register byte offsets
`define FMC_ADR_CTRL 8'h00
`define FMC_ADR_FLAGS 8'h04
`define FMC_ADR_HIGH 8'h08
`define FMC_ADR_LOW 8'h0c
`define FMC_ADR_STAT 8'h10
`define FMC_ADR_MASK 8'h14

// control register fields
`define FMC_CB_CU0 0
`define FMC_CB_CU1 1
`define FMC_CB_CU2 2
`define FMC_CB_REL2 3
`define FMC_CB_RM 5:4
`define FMC_CB_EN 11:8
`define FMC_CTRL_RST 32'h0000000f
`define FMC_CTRL_WMASK 32'h00000f3f

// flag register fields
`define FMC_FL_FLAG 4:0
`define FMC_FL_CAUSE 12:8

// interrupt status bits
`define FMC_EV_EXC 0
`define FMC_EV_FPMA 1
`define FMC_EV_UMAC 2
`define FMC_EV_W 3

`endif

// ===== rtl/fmc_pkg.sv
// types shared by the multiply-add and coprocessor move block
// assumes fmc_consts.svh is compiled alongside
package fmc_pkg;
  typedef enum logic [1:0] {FMC_FMT_SGL, FMC_FMT_DBL, FMC_FMT_PAIR} fmc_fmt_t;
  typedef enum logic [1:0] {FMC_EXC_NONE, FMC_EXC_COPU, FMC_EXC_RESV,
    FMC_EXC_FPE} fmc_exc_t;
  typedef enum logic [1:0] {FMC_ST_IDLE, FMC_ST_MUL, FMC_ST_ADD,
    FMC_ST_COP} fmc_state_t;
  typedef enum logic {FMC_FPU_MUL, FMC_FPU_ADD} fmc_fpu_op_t;
  typedef struct packed {
    logic unimpl;
    logic invalid;
    logic overflow;
    logic underflow;
    logic inexact;
  } fmc_flags_t;
  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [31:0] gpr_a;
    logic [31:0] gpr_b;
    logic [63:0] fp_a;
    logic [63:0] fp_b;
    logic [63:0] fp_c;
  } fmc_issue_t;
  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [31:0] data;
  } fmc_gpr_wr_t;
  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [63:0] data;
  } fmc_fpr_wr_t;
  typedef struct packed {
    logic req;
    fmc_fpu_op_t op;
    fmc_fmt_t fmt;
    logic [1:0] rmode;
    logic [63:0] a;
    logic [63:0] b;
  } fmc_fpu_req_t;
  typedef struct packed {
    logic ack;
    logic [63:0] result;
    fmc_flags_t hi;
    fmc_flags_t lo;
  } fmc_fpu_rsp_t;
  typedef struct packed {
    logic req;
    logic two;
    logic [15:0] addr;
  } fmc_cop_req_t;
endpackage : fmc_pkg

// ===== rtl/fmc_top.sv
// decode and execute of fp multiply-add, unsigned multiply-accumulate
// and word moves from coprocessors 0, 1 and 2 into a general register
// assumes an fp unit doing rounded multiply and add, and coprocessors
// that answer a read request with a one-cycle ack
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`include "fmc_consts.svh"

// Operation
// - decode fp multiply-add by opcode and function
// - multiply, round, add addend, round, write
// - two separately rounded steps, not fused
// - paired halves independent, exception flags ORed
// - cause bits ORed into sticky flags when nothing traps
// - fp, unusable and reserved exceptions raised
// - decode unsigned multiply-accumulate, zero field checked
// - unsigned 64-bit product added into high/low
// - accumulate writes no general register, no exception
// - decode system coprocessor move, zero field checked
// - system register by index and sub-select
// - system move raises unusable or reserved
// - fp low-word move, uninterpreted low word
// - coprocessor two move passes specifier through
// - coprocessor two move raises unusable when disabled
// - fp high-word move copies upper word
// - high-word move reserved before release two
module fmc_top
  import fmc_pkg::*;
#(
  parameter int ADR_W = 8
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire fmc_issue_t issue_i,
  output logic busy_o,
  output logic done_o,
  output logic exc_o,
  output fmc_exc_t exc_code_o,
  output fmc_gpr_wr_t gpr_wr_o,
  output fmc_fpr_wr_t fpr_wr_o,
  output fmc_fpu_req_t fpu_req_o,
  input wire fmc_fpu_rsp_t fpu_rsp_i,
  output fmc_cop_req_t cop_req_o,
  input wire logic cop_ack_i,
  input wire logic [31:0] cop_rdata_i,
  output logic [31:0] product_high_o,
  output logic [31:0] product_low_o,
  output fmc_flags_t fp_flags_o
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------

  // byte-lane merge of a bus write into an old value
  function automatic logic [31:0] wmerge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : wmerge

  // unimplemented always traps, the others only when enabled
  function automatic logic fp_trap(input fmc_flags_t f,
    input logic [3:0] en);
    return f.unimpl | (|(f[3:0] & en));
  endfunction : fp_trap

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  fmc_state_t st_reg, st_next;
  logic done_reg, done_next;
  logic exc_reg, exc_next;
  fmc_exc_t code_reg, code_next;
  fmc_gpr_wr_t gw_reg, gw_next;
  fmc_fpr_wr_t fw_reg, fw_next;
  fmc_fpu_req_t fpu_reg, fpu_next;
  fmc_cop_req_t cop_reg, cop_next;
  logic [63:0] hilo_reg, hilo_next;
  logic [4:0] tgt_reg, tgt_next;
  logic [4:0] fdst_reg, fdst_next;
  logic [63:0] addend_reg, addend_next;
  fmc_flags_t mulc_reg, mulc_next;
  fmc_flags_t cause_reg, flag_reg, cause_set, flag_set;
  logic cause_wr, ev_fpma, ev_umac;
  logic [31:0] ctrl_reg;
  logic [`FMC_EV_W-1:0] stat_reg, mask_reg, events;
  logic [31:0] dat_reg;
  logic ack_reg, irq_reg, busy_reg;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic [31:0] ins = issue_i.instr;
  wire logic [5:0] opc = ins[`FMC_OPC];
  wire logic [4:0] sub = ins[`FMC_SUB];
  wire logic [2:0] fmt = ins[`FMC_FMT];
  wire logic cu0 = ctrl_reg[`FMC_CB_CU0];
  wire logic cu1 = ctrl_reg[`FMC_CB_CU1];
  wire logic cu2 = ctrl_reg[`FMC_CB_CU2];
  wire logic rel2 = ctrl_reg[`FMC_CB_REL2];
  wire logic [1:0] rmode = ctrl_reg[`FMC_CB_RM];
  wire logic [3:0] fp_en = ctrl_reg[`FMC_CB_EN];

  // extended fp major op with madd function
  wire logic is_fpma = (opc == `FMC_OP_FPX) &&
    (ins[`FMC_F3] == `FMC_F3_MADD);
  // second special op, function and zero field
  wire logic is_umac = (opc == `FMC_OP_SP2) &&
    (ins[`FMC_FN] == `FMC_FN_UMAC) && (ins[`FMC_Z_UMAC] == '0);
  wire logic is_sys = (opc == `FMC_OP_SYS) && (sub == `FMC_SUB_MF) &&
    (ins[`FMC_Z_SYS] == '0);
  wire logic is_fplo = (opc == `FMC_OP_FPC) && (sub == `FMC_SUB_MF) &&
    (ins[`FMC_Z_FPC] == '0);
  wire logic is_fphi = (opc == `FMC_OP_FPC) && (sub == `FMC_SUB_MFH) &&
    (ins[`FMC_Z_FPC] == '0);
  wire logic is_cp2 = (opc == `FMC_OP_CP2) && (sub == `FMC_SUB_MF);

  wire logic fmt_s = (fmt == `FMC_FMT_S);
  wire logic fmt_d = (fmt == `FMC_FMT_D);
  wire logic fmt_ps = (fmt == `FMC_FMT_PS);
  wire logic fmt_ok = fmt_s | fmt_d | fmt_ps;
  wire fmc_fmt_t fmt_dec = fmt_ps ? FMC_FMT_PAIR :
    (fmt_d ? FMC_FMT_DBL : FMC_FMT_SGL);

  wire logic known = is_fpma | is_umac | is_sys | is_fplo | is_fphi |
    is_cp2;
  wire logic exc_cpu = (is_sys & ~cu0) |
    ((is_fpma | is_fplo | is_fphi) & ~cu1) | (is_cp2 & ~cu2);
  // high-word move reserved before release two
  wire logic exc_ri = ~known | (is_fphi & ~rel2) | (is_fpma & ~fmt_ok);
  // unusable wins over reserved for a known op
  wire logic exc_any = exc_cpu | exc_ri;
  wire fmc_exc_t exc_dec = exc_cpu ? FMC_EXC_COPU : FMC_EXC_RESV;

  wire logic accept = issue_i.valid & (st_reg == FMC_ST_IDLE);

  // unsigned 32x32 product added to the high/low pair
  wire logic [63:0] umac_sum = hilo_reg +
    ({32'h0, issue_i.gpr_a} * {32'h0, issue_i.gpr_b});

  // index and sub-select form the system address
  wire logic [15:0] sys_addr = {8'h00, ins[`FMC_RD], ins[`FMC_SEL]};

  // paired halves report separately, combined by OR
  wire fmc_flags_t lane_or = fmc_flags_t'(fpu_rsp_i.hi | fpu_rsp_i.lo);
  wire fmc_flags_t sum_c = fmc_flags_t'(mulc_reg | lane_or);

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------

  // next-state logic; outputs of every path are registered below
  always_comb
  begin
    st_next = st_reg;
    done_next = 1'b0;
    exc_next = 1'b0;
    code_next = code_reg;
    gw_next = gw_reg;
    gw_next.we = 1'b0;
    fw_next = fw_reg;
    fw_next.we = 1'b0;
    fpu_next = fpu_reg;
    cop_next = cop_reg;
    hilo_next = hilo_reg;
    tgt_next = tgt_reg;
    fdst_next = fdst_reg;
    addend_next = addend_reg;
    mulc_next = mulc_reg;
    cause_set = '0;
    flag_set = '0;
    cause_wr = 1'b0;
    ev_fpma = 1'b0;
    ev_umac = 1'b0;
    unique case (st_reg)
      FMC_ST_IDLE:
      begin
        if (accept)
        begin
          tgt_next = ins[`FMC_RT];
          fdst_next = ins[`FMC_FD];
          addend_next = issue_i.fp_c;
          if (exc_any)
          begin
            exc_next = 1'b1;
            code_next = exc_dec;
            done_next = 1'b1;
          end
          else if (is_umac)
          begin
            // only high/low change, no register write
            hilo_next = umac_sum;
            done_next = 1'b1;
            ev_umac = 1'b1;
          end
          else if (is_fplo | is_fphi)
          begin
            gw_next.we = 1'b1;
            gw_next.addr = ins[`FMC_RT];
            gw_next.data = is_fphi ? issue_i.fp_a[`FMC_HI] :
              issue_i.fp_a[`FMC_LO];
            done_next = 1'b1;
          end
          else if (is_fpma)
          begin
            fpu_next.req = 1'b1;
            fpu_next.op = FMC_FPU_MUL;
            fpu_next.fmt = fmt_dec;
            fpu_next.rmode = rmode;
            fpu_next.a = issue_i.fp_a;
            fpu_next.b = issue_i.fp_b;
            st_next = FMC_ST_MUL;
          end
          else
          begin
            cop_next.req = 1'b1;
            cop_next.two = is_cp2;
            cop_next.addr = is_cp2 ? ins[`FMC_IMPL] : sys_addr;
            st_next = FMC_ST_COP;
          end
        end
      end
      FMC_ST_COP:
      begin
        if (cop_ack_i)
        begin
          cop_next.req = 1'b0;
          gw_next.we = 1'b1;
          gw_next.addr = tgt_reg;
          gw_next.data = cop_rdata_i;
          done_next = 1'b1;
          st_next = FMC_ST_IDLE;
        end
      end
      FMC_ST_MUL:
      begin
        if (fpu_rsp_i.ack)
        begin
          mulc_next = lane_or;
          if (fp_trap(lane_or, fp_en))
          begin
            // a trapping product stops as a lone multiply would
            fpu_next.req = 1'b0;
            cause_set = lane_or;
            cause_wr = 1'b1;
            exc_next = 1'b1;
            code_next = FMC_EXC_FPE;
            done_next = 1'b1;
            st_next = FMC_ST_IDLE;
          end
          else
          begin
            // second step: rounded sum with the addend
            fpu_next.op = FMC_FPU_ADD;
            fpu_next.a = fpu_rsp_i.result;
            fpu_next.b = addend_reg;
            st_next = FMC_ST_ADD;
          end
        end
      end
      FMC_ST_ADD:
      begin
        if (fpu_rsp_i.ack)
        begin
          fpu_next.req = 1'b0;
          cause_set = sum_c;
          cause_wr = 1'b1;
          done_next = 1'b1;
          st_next = FMC_ST_IDLE;
          if (fp_trap(lane_or, fp_en))
          begin
            exc_next = 1'b1;
            code_next = FMC_EXC_FPE;
          end
          else
          begin
            fw_next.we = 1'b1;
            fw_next.addr = fdst_reg;
            fw_next.data = fpu_rsp_i.result;
            // no trap: causes go into the sticky flags
            flag_set = sum_c;
            ev_fpma = 1'b1;
          end
        end
      end
    endcase
  end

  // sequencer and retire registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= FMC_ST_IDLE;
      done_reg <= 1'b0;
      exc_reg <= 1'b0;
      code_reg <= FMC_EXC_NONE;
      gw_reg <= '0;
      fw_reg <= '0;
      fpu_reg <= '0;
      cop_reg <= '0;
      hilo_reg <= '0;
      tgt_reg <= '0;
      fdst_reg <= '0;
      addend_reg <= '0;
      mulc_reg <= '0;
      busy_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      done_reg <= done_next;
      exc_reg <= exc_next;
      code_reg <= code_next;
      gw_reg <= gw_next;
      fw_reg <= fw_next;
      fpu_reg <= fpu_next;
      cop_reg <= cop_next;
      hilo_reg <= hilo_next;
      tgt_reg <= tgt_next;
      fdst_reg <= fdst_next;
      addend_reg <= addend_next;
      mulc_reg <= mulc_next;
      busy_reg <= (st_next != FMC_ST_IDLE);
    end
  end

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------

  // one access per strobe; ack low in the cycle after it was given
  wire logic wb_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire logic wb_wr = wb_hit & wb_we_i;
  wire logic [7:0] adr = 8'(wb_adr_i);
  wire logic sel_ctrl = (adr == `FMC_ADR_CTRL);
  wire logic sel_flags = (adr == `FMC_ADR_FLAGS);
  wire logic sel_high = (adr == `FMC_ADR_HIGH);
  wire logic sel_low = (adr == `FMC_ADR_LOW);
  wire logic sel_stat = (adr == `FMC_ADR_STAT);
  wire logic sel_mask = (adr == `FMC_ADR_MASK);

  // flag word: sticky flags low, last cause above
  logic [31:0] flags_word;
  always_comb
  begin
    flags_word = '0;
    flags_word[`FMC_FL_FLAG] = flag_reg;
    flags_word[`FMC_FL_CAUSE] = cause_reg;
  end

  wire logic [31:0] flags_wv = wmerge(flags_word, wb_dat_i, wb_sel_i);
  wire logic [31:0] ctrl_wv = wmerge(ctrl_reg, wb_dat_i, wb_sel_i);
  wire logic [31:0] mask_wv = wmerge(32'(mask_reg), wb_dat_i, wb_sel_i);
  wire logic [31:0] w1c_v = wmerge(32'h0, wb_dat_i, wb_sel_i);

  // unmapped offsets read as zero and ignore writes
  wire logic [31:0] rd_data =
    sel_ctrl ? ctrl_reg :
    sel_flags ? flags_word :
    sel_high ? hilo_reg[`FMC_HI] :
    sel_low ? hilo_reg[`FMC_LO] :
    sel_stat ? 32'(stat_reg) :
    sel_mask ? 32'(mask_reg) : 32'h0;

  assign events[`FMC_EV_EXC] = exc_next;
  assign events[`FMC_EV_FPMA] = ev_fpma;
  assign events[`FMC_EV_UMAC] = ev_umac;

  // bus answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end
    else
    begin
      ack_reg <= wb_hit;
      dat_reg <= wb_hit ? rd_data : dat_reg;
    end
  end

  // software registers; hardware sets win over software clears
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= `FMC_CTRL_RST;
      mask_reg <= '0;
      stat_reg <= '0;
      flag_reg <= '0;
      cause_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      if (wb_wr && sel_ctrl)
        ctrl_reg <= ctrl_wv & `FMC_CTRL_WMASK;
      if (wb_wr && sel_mask)
        mask_reg <= mask_wv[`FMC_EV_W-1:0];
      stat_reg <= (stat_reg & ~((wb_wr && sel_stat) ?
        w1c_v[`FMC_EV_W-1:0] : '0)) | events;
      // sticky flags accumulate; software may rewrite them
      flag_reg <= fmc_flags_t'(((wb_wr && sel_flags) ?
        flags_wv[`FMC_FL_FLAG] : flag_reg) | flag_set);
      if (cause_wr)
        cause_reg <= cause_set;
      irq_reg <= |(stat_reg & mask_reg);
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;
  assign irq_o = irq_reg;
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign exc_o = exc_reg;
  assign exc_code_o = code_reg;
  assign gpr_wr_o = gw_reg;
  assign fpr_wr_o = fw_reg;
  assign fpu_req_o = fpu_reg;
  assign cop_req_o = cop_reg;
  assign product_high_o = hilo_reg[`FMC_HI];
  assign product_low_o = hilo_reg[`FMC_LO];
  assign fp_flags_o = flag_reg;

endmodule : fmc_top

// ===== sim/fmc_checker.sv
// port assertions for the multiply-add and coprocessor move block
// assumes one clock and the block's synchronous reset
`timescale 1ns/10ps
`include "fmc_consts.svh"
module fmc_checker
  import fmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire fmc_issue_t issue_i,
  input wire logic busy_o,
  input wire logic exc_o,
  input wire fmc_gpr_wr_t gpr_wr_o,
  input wire fmc_fpu_req_t fpu_req_o,
  input wire fmc_fpu_rsp_t fpu_rsp_i,
  input wire fmc_cop_req_t cop_req_o,
  input wire logic [31:0] product_high_o,
  input wire logic [31:0] product_low_o
);
  // --------
  // decode of accepted instructions
  // --------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic [31:0] ins = issue_i.instr;
  wire logic acc = issue_i.valid && !busy_o;
  wire logic [5:0] opc = ins[`FMC_OPC];
  wire logic mf = ins[`FMC_SUB] == `FMC_SUB_MF;
  wire logic umac = acc && opc == `FMC_OP_SP2
    && ins[`FMC_FN] == `FMC_FN_UMAC && ins[`FMC_Z_UMAC] == 10'h000;
  wire logic fpc = acc && opc == `FMC_OP_FPC && ins[`FMC_Z_FPC] == 11'h0;
  wire logic madd = acc && opc == `FMC_OP_FPX
    && ins[`FMC_F3] == `FMC_F3_MADD && ins[2:0] inside {3'h0, 3'h1, 3'h6};
  wire logic [63:0] hilo = {product_high_o, product_low_o};

  // --------
  // assertions
  // --------
  ack_one_cycle_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1
      !wb_ack_o) else $error("ack not one pulse");
  umac_sum_a:
    assert property (umac |=> hilo == $past(hilo)
      + $past(issue_i.gpr_a) * $past(issue_i.gpr_b))
      else $error("accumulate sum wrong");
  umac_no_write_a:
    assert property (umac |=> !gpr_wr_o.we && !exc_o)
      else $error("accumulate side effect");
  fp_low_a:
    assert property (fpc && mf |=> exc_o || (gpr_wr_o.we
      && gpr_wr_o.data == $past(issue_i.fp_a[31:0])))
      else $error("fp low word move wrong");
  fp_high_a:
    assert property (fpc && ins[`FMC_SUB] == `FMC_SUB_MFH |=> exc_o
      || (gpr_wr_o.we && gpr_wr_o.data == $past(issue_i.fp_a[63:32])))
      else $error("fp high word move wrong");
  sys_addr_a:
    assert property (acc && opc == `FMC_OP_SYS && mf
      && ins[`FMC_Z_SYS] == 8'h00 |=> exc_o || (cop_req_o.req
      && !cop_req_o.two && cop_req_o.addr == {8'h00, $past(ins[15:11]),
      $past(ins[2:0])})) else $error("system move specifier wrong");
  cop_two_major_op_addr_a:
    assert property (acc && opc == `FMC_OP_CP2 && mf |=> exc_o
      || (cop_req_o.req && cop_req_o.two
      && cop_req_o.addr == $past(ins[15:0])))
      else $error("coprocessor two specifier wrong");
  madd_mul_a:
    assert property (madd |=> exc_o || (fpu_req_o.req
      && fpu_req_o.op == FMC_FPU_MUL && fpu_req_o.a == $past(issue_i.fp_a)
      && fpu_req_o.b == $past(issue_i.fp_b)))
      else $error("multiply step not issued");
  madd_chain_a:
    assert property (fpu_req_o.req && fpu_req_o.op == FMC_FPU_MUL
      && fpu_rsp_i.ack |=> exc_o || (fpu_req_o.req
      && fpu_req_o.op == FMC_FPU_ADD && fpu_req_o.a == $past(fpu_rsp_i.result)))
      else $error("add step operand wrong");
  cover property (umac);
  cover property (fpu_rsp_i.ack && fpu_req_o.op == FMC_FPU_ADD);
  cover property (cop_req_o.req && cop_req_o.two);
endmodule : fmc_checker

bind fmc_top fmc_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .issue_i(issue_i), .busy_o(busy_o), .exc_o(exc_o),
  .gpr_wr_o(gpr_wr_o), .fpu_req_o(fpu_req_o), .fpu_rsp_i(fpu_rsp_i),
  .cop_req_o(cop_req_o), .product_high_o(product_high_o),
  .product_low_o(product_low_o)
);

// ===== sim/fmc_far_model.sv
// far-side model: fp unit and coprocessor read port
// assumes each request is held until its one-cycle ack
`timescale 1ns/10ps
module fmc_far_model
  import fmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire fmc_flags_t mul_flg_i,
  input wire fmc_flags_t add_flg_i,
  input wire fmc_flags_t hi_flg_i,
  input wire fmc_fpu_req_t fpu_req_i,
  output fmc_fpu_rsp_t fpu_rsp_o,
  input wire fmc_cop_req_t cop_req_i,
  output logic cop_ack_o,
  output logic [31:0] cop_rdata_o
);
  // --------
  // answers
  // --------
  logic [1:0] f_cnt_reg;
  logic [1:0] c_cnt_reg;
  wire logic [1:0] wait_n = slow_i ? 2'h3 : 2'h0;
  wire logic mul = fpu_req_i.op == FMC_FPU_MUL;

  // idle data inverts every cycle so a stale word never matches
  // rounded steps, half flags, specifier read
  always_ff @(posedge clk_i)
  begin
    fpu_rsp_o.ack <= 1'b0;
    cop_ack_o <= 1'b0;
    fpu_rsp_o.result <= ~fpu_rsp_o.result;
    cop_rdata_o <= ~cop_rdata_o;
    f_cnt_reg <= 2'h0;
    c_cnt_reg <= 2'h0;
    if (fpu_req_i.req && !fpu_rsp_o.ack)
    begin
      f_cnt_reg <= f_cnt_reg + 2'h1;
      if (f_cnt_reg == wait_n)
      begin
        fpu_rsp_o.ack <= 1'b1;
        fpu_rsp_o.result <= mul ? fpu_req_i.a ^ fpu_req_i.b
                                : fpu_req_i.a + fpu_req_i.b;
        fpu_rsp_o.lo <= mul ? mul_flg_i : add_flg_i;
        fpu_rsp_o.hi <= (fpu_req_i.fmt == FMC_FMT_PAIR) ? hi_flg_i : '0;
      end
    end
    if (cop_req_i.req && !cop_ack_o)
    begin
      c_cnt_reg <= c_cnt_reg + 2'h1;
      if (c_cnt_reg == wait_n)
      begin
        cop_ack_o <= 1'b1;
        cop_rdata_o <= {16'hc0de, cop_req_i.addr};
      end
    end
    if (rst_i)
    begin
      fpu_rsp_o <= '0;
      cop_rdata_o <= 32'h0;
    end
  end
endmodule : fmc_far_model

// ===== sim/tb.sv
// self-checking bench for the multiply-add and coprocessor move block
// assumes the far-side model answers fp and coprocessor requests
`timescale 1ns/10ps
`include "fmc_consts.svh"
module tb
  import fmc_pkg::*;
;
  // --------
  // signals and instances
  // --------
  localparam logic [63:0] FA = 64'h1122334455667788;
  localparam logic [63:0] FB = 64'h0f0f0f0f0f0f0f0f;
  localparam logic [63:0] FC = 64'h0000000100000001;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  fmc_issue_t iss = '0;
  fmc_flags_t mflg = 5'h01, aflg = 5'h04, hflg = 5'h02;
  logic [31:0] rdat, cdat, phi, plo;
  logic ack, irq, busy, done, exc, cack;
  fmc_exc_t code;
  fmc_gpr_wr_t gw;
  fmc_fpr_wr_t fw;
  fmc_fpu_req_t freq;
  fmc_fpu_rsp_t frsp;
  fmc_cop_req_t creq;
  fmc_flags_t flags;
  logic [3:0] last_rq;
  logic [4:0] e;
  logic [2:0] fmts [3] = '{3'h0, 3'h1, 3'h6};
  fmc_fmt_t fe [3] = '{FMC_FMT_SGL, FMC_FMT_DBL, FMC_FMT_PAIR};
  int n_errors = 0;
  int samples_checked = 0;

  // half-period toggle gives the 25 ns clock
  always #12.5 clk_i = ~clk_i;

  // remember the mode and format handed to the fp unit
  always @(posedge clk_i)
    if (freq.req)
      last_rq <= {freq.rmode, freq.fmt};

  fmc_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .issue_i(iss),
    .busy_o(busy), .done_o(done), .exc_o(exc), .exc_code_o(code),
    .gpr_wr_o(gw), .fpr_wr_o(fw), .fpu_req_o(freq), .fpu_rsp_i(frsp),
    .cop_req_o(creq), .cop_ack_i(cack), .cop_rdata_i(cdat),
    .product_high_o(phi), .product_low_o(plo), .fp_flags_o(flags)
  );
  fmc_far_model u_far (
    .clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .mul_flg_i(mflg),
    .add_flg_i(aflg), .hi_flg_i(hflg), .fpu_req_i(freq), .fpu_rsp_o(frsp),
    .cop_req_i(creq), .cop_ack_o(cack), .cop_rdata_o(cdat)
  );

  // --------
  // tasks
  // --------
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic hang();
    n_errors++;
    report_and_stop();
  endtask : hang

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; the request holds until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    for (n = 1; ack !== 1'b1 && n < 20; n++)
      @(posedge clk_i);
    if (ack !== 1'b1)
      hang();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, x);
  endtask : rd

  // issue one instruction, return in its done cycle
  task automatic run(input logic [31:0] i, input logic [31:0] ga, gb,
                     input logic [63:0] fa, fb, fc);
    int n;
    iss <= '{1'b1, i, ga, gb, fa, fb, fc};
    @(posedge clk_i);
    for (n = 1; busy !== 1'b0 && n < 20; n++)
      @(posedge clk_i);
    if (busy !== 1'b0)
      hang();
    iss.valid <= 1'b0;
    @(posedge clk_i);
    for (n = 1; done !== 1'b1 && n < 50; n++)
      @(posedge clk_i);
    if (done !== 1'b1)
      hang();
  endtask : run

  // --------
  // main sequence
  // --------
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`FMC_ADR_CTRL, 32'h0000000f);
    rd(`FMC_ADR_STAT, 32'h0);
    rd(8'h18, 32'h0);
    wr(`FMC_ADR_CTRL, 32'hffffffff);
    rd(`FMC_ADR_CTRL, 32'h00000f3f);
    wr(`FMC_ADR_CTRL, 32'h0000000f);
    run(32'h70220001, 32'hffffffff, 32'hffffffff, 0, 0, 0);
    chk({gw.we, exc}, 2'b00);
    run(32'h70220001, 32'h2, 32'h3, 0, 0, 0);
    chk({phi, plo}, 64'hfffffffe00000007);
    rd(`FMC_ADR_HIGH, 32'hfffffffe);
    run(32'h70220041, 32'h2, 32'h3, 0, 0, 0);
    chk(code, FMC_EXC_RESV);
    chk(plo, 32'h00000007);
    run(32'h44071800, 0, 0, FA, 0, 0);
    chk({gw.addr, gw.data}, {5'd7, FA[31:0]});
    run(32'h44671800, 0, 0, FA, 0, 0);
    chk(gw.data, FA[63:32]);
    wr(`FMC_ADR_CTRL, 32'h7);
    run(32'h44671800, 0, 0, FA, 0, 0);
    chk(code, FMC_EXC_RESV);
    wr(`FMC_ADR_CTRL, 32'hd);
    run(32'h44071800, 0, 0, FA, 0, 0);
    chk(code, FMC_EXC_COPU);
    wr(`FMC_ADR_CTRL, 32'hb);
    slow <= 1'b1;
    run(32'h40096002, 0, 0, 0, 0, 0);
    chk({gw.addr, gw.data}, {5'd9, 32'hc0de0062});
    run(32'h4009600a, 0, 0, 0, 0, 0);
    chk(exc, 1'b1);
    run(32'h48041234, 0, 0, 0, 0, 0);
    chk(code, FMC_EXC_COPU);
    wr(`FMC_ADR_CTRL, 32'hf);
    run(32'h48041234, 0, 0, 0, 0, 0);
    chk(gw.data, 32'hc0de1234);
    // each format issued with rounding mode equal to its index; double runs slow
    foreach (fmts[i])
    begin
      slow <= fmts[i][0];
      wr(`FMC_ADR_CTRL, 32'hf | (i << 4));
      wr(`FMC_ADR_FLAGS, 32'h0);
      run(32'h4c221960 + fmts[i], 0, 0, FA, FB, FC);
      chk({fw.addr, fw.data}, {5'd5, (FA ^ FB) + FC});
      chk(last_rq, {2'(i), fe[i]});
      e = (fmts[i] == 3'h6) ? 5'h07 : 5'h05;
      chk(flags, e);
      rd(`FMC_ADR_FLAGS, {19'h0, e, 3'h0, e});
    end
    run(32'h4c221962, 0, 0, FA, FB, FC);
    chk(code, FMC_EXC_RESV);
    mflg <= 5'h10;
    wr(`FMC_ADR_FLAGS, 32'h0);
    run(32'h4c221960, 0, 0, FA, FB, FC);
    chk(code, FMC_EXC_FPE);
    chk({fw.we, flags}, 6'h00);
    rd(`FMC_ADR_STAT, 32'h7);
    chk(irq, 1'b0);
    wr(`FMC_ADR_MASK, 32'h2);
    chk(irq, 1'b1);
    wr(`FMC_ADR_STAT, 32'h2);
    rd(`FMC_ADR_STAT, 32'h5);
    chk(irq, 1'b0);
    report_and_stop();
  end
endmodule : tb
